// file: hw/iloe_pkg.sv
// Constants and types shared by the indexed literal offset executor.
package iloe_pkg;

  // ---------------------------------------------------------------
  // Addressing constants
  // ---------------------------------------------------------------
  localparam logic [7:0] OFFSET_LIMIT   = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
  localparam logic [3:0] ACCESS_HI_PAGE = 4'hf;
  localparam logic [7:0] ALL_ONES       = 8'hff;

  // ---------------------------------------------------------------
  // Opcode patterns
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_ADD  = 6'h09;
  localparam logic [3:0] OPC_BSF  = 4'h8;
  localparam logic [6:0] OPC_SET_FILE_ALL_ONES = 7'h34;
  localparam int         POS_DEST = 9;
  localparam int         POS_ACC  = 8;
  localparam int         POS_BIT  = 9;

  // ---------------------------------------------------------------
  // Register port map and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  REG_ACC    = 2'h0;
  localparam logic [1:0]  REG_FRAME  = 2'h1;
  localparam logic [1:0]  REG_BANK   = 2'h2;
  localparam logic [1:0]  REG_FLAGS  = 2'h3;
  localparam logic [7:0]  RST_ACC    = 8'h00;
  localparam logic [11:0] RST_FRAME  = 12'h000;
  localparam logic [3:0]  RST_BANK   = 4'h0;
  localparam logic [4:0]  RST_FLAGS  = 5'h00;
  localparam logic [15:0] RST_INSTR  = 16'h0000;

  // Status flag positions: negative, overflow, zero, digit carry, carry.
  localparam int FLAG_N  = 4;
  localparam int FLAG_OV = 3;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_DC = 1;
  localparam int FLAG_C  = 0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_EXEC = 3'b100
  } iloe_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_ADD  = 2'h1,
    OP_BSF  = 2'h2,
    OP_SET_FILE_ALL_ONES = 2'h3
  } iloe_op_t;

endpackage

// file: hw/iloe_addr_gen.sv
// Effective data address former for file register operands.
`timescale 1ns/10ps
module iloe_addr_gen (
  input  wire logic        ext_en,
  input  wire logic        acc_sel,
  input  wire logic [7:0]  file_arg,
  input  wire logic [11:0] stack_frame_pointer,
  input  wire logic [3:0]  bank_select_register,
  output logic      [11:0] eff_addr,
  output logic             indexed
);

  logic [11:0] access_addr;
  logic [11:0] frame_addr;

  always_comb begin
    access_addr = (file_arg < iloe_pkg::ACCESS_SPLIT) ? {iloe_pkg::ACCESS_LO_PAGE, file_arg}
                                                       : {iloe_pkg::ACCESS_HI_PAGE, file_arg};
    frame_addr  = stack_frame_pointer + {4'h0, file_arg};
    indexed     = ext_en & ~acc_sel & (file_arg <= iloe_pkg::OFFSET_LIMIT);
    if (indexed) begin
      eff_addr = frame_addr;
    end else if (acc_sel) begin
      eff_addr = {bank_select_register, file_arg};
    end else begin
      eff_addr = access_addr;
    end
  end

endmodule // iloe_addr_gen

// file: hw/iloe_alu.sv
// Byte adder producing the arithmetic status flags.
`timescale 1ns/10ps
module iloe_alu (
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  output logic      [7:0] sum,
  output logic      [4:0] flags
);

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full  = {1'b0, op_a} + {1'b0, op_b};
    low   = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
    sum   = full[7:0];
    flags = '0;
    flags[iloe_pkg::FLAG_N]  = full[7];
    flags[iloe_pkg::FLAG_OV] = (op_a[7] == op_b[7]) && (full[7] != op_a[7]);
    flags[iloe_pkg::FLAG_Z]  = (full[7:0] == 8'h00);
    flags[iloe_pkg::FLAG_DC] = low[4];
    flags[iloe_pkg::FLAG_C]  = full[8];
  end

endmodule // iloe_alu

// file: hw/iloe_exec.sv
// Executor for add, bit-set and set-all-ones with indexed literal offset addressing.
`timescale 1ns/10ps

module iloe_exec (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        extended_set_enable_bit,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  output logic             instr_ready,
  output logic      [11:0] mem_addr,
  output logic             mem_rd_en,
  input  wire logic [7:0]  mem_rd_data,
  output logic             mem_wr_en,
  output logic      [7:0]  mem_wr_data,
  output logic             indexed_access,
  output logic      [7:0]  acc_value,
  output logic      [4:0]  status_flags,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wr_data,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rd_data
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    iloe_pkg::iloe_state_t state;
    logic [1:0]            en_sync;
    logic [7:0]            acc;
    logic [11:0]           stack_frame_pointer;
    logic [3:0]            bank_select_register;
    logic [4:0]            flags;
    logic [15:0]           instr;
    logic [11:0]           addr;
    logic                  indexed;
    logic                  rd_en;
    logic                  wr_en;
    logic [7:0]            wr_data;
    logic                  ready;
    logic [15:0]           rd_data;
  } iloe_st_t;

  iloe_st_t s_r;
  iloe_st_t s_nxt;

  logic              ext_en;
  logic              accept;
  iloe_pkg::iloe_op_t op_in;
  iloe_pkg::iloe_op_t op_cur;
  logic [11:0]       ag_addr;
  logic              ag_indexed;
  logic [7:0]        alu_sum;
  logic [4:0]        alu_flags;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic iloe_pkg::iloe_op_t op_of(input logic [15:0] w);
    if (w[15:10] == iloe_pkg::OPC_ADD && !w[8]) begin
      op_of = iloe_pkg::OP_ADD;
    end else if (w[15:10] == iloe_pkg::OPC_ADD) begin
      op_of = iloe_pkg::OP_ADD;
    end else if (w[15:12] == iloe_pkg::OPC_BSF) begin
      op_of = iloe_pkg::OP_BSF;
    end else if (w[15:9] == iloe_pkg::OPC_SET_FILE_ALL_ONES) begin
      op_of = iloe_pkg::OP_SET_FILE_ALL_ONES;
    end else begin
      op_of = iloe_pkg::OP_NONE;
    end
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // The enable bit is a configuration level from outside this clock.
  // A change therefore reaches the decoder two edges late, so software must let it
  // settle before it issues work that relies on indexed operands.
  assign ext_en = s_r.en_sync[1];
  assign accept = s_r.ready & instr_valid;
  assign op_in  = op_of(instr_word);
  assign op_cur = op_of(s_r.instr);

  iloe_addr_gen u_addr_gen (
    .ext_en               (ext_en),
    .acc_sel              (instr_word[iloe_pkg::POS_ACC]),
    .file_arg             (instr_word[7:0]),
    .stack_frame_pointer  (s_r.stack_frame_pointer),
    .bank_select_register (s_r.bank_select_register),
    .eff_addr             (ag_addr),
    .indexed              (ag_indexed)
  );

  iloe_alu u_alu (
    .op_a  (s_r.acc),
    .op_b  (mem_rd_data),
    .sum   (alu_sum),
    .flags (alu_flags)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt         = s_r;
    s_nxt.en_sync = {s_r.en_sync[0], extended_set_enable_bit};
    s_nxt.rd_en   = 1'b0;
    s_nxt.wr_en   = 1'b0;
    s_nxt.rd_data = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        iloe_pkg::REG_ACC:   s_nxt.rd_data = {8'h00, s_r.acc};
        iloe_pkg::REG_FRAME: s_nxt.rd_data = {4'h0, s_r.stack_frame_pointer};
        iloe_pkg::REG_BANK:  s_nxt.rd_data = {12'h000, s_r.bank_select_register};
        iloe_pkg::REG_FLAGS: s_nxt.rd_data = {11'h000, s_r.flags};
        default:             s_nxt.rd_data = 16'h0000;
      endcase
    end
    // Software writes land first so that an executing instruction wins.
    if (reg_wr) begin
      case (reg_addr)
        iloe_pkg::REG_ACC:   s_nxt.acc = reg_wr_data[7:0];
        iloe_pkg::REG_FRAME: s_nxt.stack_frame_pointer = reg_wr_data[11:0];
        iloe_pkg::REG_BANK:  s_nxt.bank_select_register = reg_wr_data[3:0];
        iloe_pkg::REG_FLAGS: s_nxt.flags = reg_wr_data[4:0];
        default:             s_nxt.flags = s_nxt.flags;
      endcase
    end
    case (s_r.state)
      iloe_pkg::ST_IDLE: begin
        if (accept) begin
          s_nxt.instr   = instr_word;
          s_nxt.addr    = ag_addr;
          s_nxt.indexed = ag_indexed;
          if (op_in == iloe_pkg::OP_SET_FILE_ALL_ONES) begin
            s_nxt.wr_en   = 1'b1;
            s_nxt.wr_data = iloe_pkg::ALL_ONES;
          end else if (op_in != iloe_pkg::OP_NONE) begin
            s_nxt.rd_en = 1'b1;
            s_nxt.ready = 1'b0;
            s_nxt.state = iloe_pkg::ST_READ;
          end
        end
      end
      iloe_pkg::ST_READ: begin
        s_nxt.state = iloe_pkg::ST_EXEC;
      end
      iloe_pkg::ST_EXEC: begin
        s_nxt.state = iloe_pkg::ST_IDLE;
        s_nxt.ready = 1'b1;
        if (op_cur == iloe_pkg::OP_ADD) begin
          if (s_r.instr[iloe_pkg::POS_DEST]) begin
            s_nxt.wr_en   = 1'b1;
            s_nxt.wr_data = alu_sum;
          end else begin
            s_nxt.acc = alu_sum;
          end
          s_nxt.flags = alu_flags;
        end else begin
          s_nxt.wr_en   = 1'b1;
          s_nxt.wr_data = mem_rd_data | bit_mask(s_r.instr[iloe_pkg::POS_BIT +: 3]);
        end
      end
      default: begin
        s_nxt.state = iloe_pkg::ST_IDLE;
        s_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{state:                iloe_pkg::ST_IDLE,
               en_sync:              2'h0,
               acc:                  iloe_pkg::RST_ACC,
               stack_frame_pointer:  iloe_pkg::RST_FRAME,
               bank_select_register: iloe_pkg::RST_BANK,
               flags:                iloe_pkg::RST_FLAGS,
               instr:                iloe_pkg::RST_INSTR,
               addr:                 12'h000,
               indexed:              1'b0,
               rd_en:                1'b0,
               wr_en:                1'b0,
               wr_data:              8'h00,
               ready:                1'b1,
               rd_data:              16'h0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign instr_ready    = s_r.ready;
  assign mem_addr       = s_r.addr;
  assign mem_rd_en      = s_r.rd_en;
  assign mem_wr_en      = s_r.wr_en;
  assign mem_wr_data    = s_r.wr_data;
  assign indexed_access = s_r.indexed;
  assign acc_value      = s_r.acc;
  assign status_flags   = s_r.flags;
  assign reg_rd_data    = s_r.rd_data;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_index_addr_form: assert property (
    accept && ext_en && !instr_word[8] && instr_word[7:0] <= iloe_pkg::OFFSET_LIMIT
    |=> s_r.indexed && s_r.addr == 12'($past(s_r.stack_frame_pointer) + {4'h0, s_r.instr[7:0]}))
    else $error("Indexed address is not frame plus offset.");

  a_high_arg_abs: assert property (
    accept && !instr_word[8] && instr_word[7:0] > iloe_pkg::OFFSET_LIMIT
    |=> !s_r.indexed && s_r.addr[7:0] == s_r.instr[7:0])
    else $error("Operand above window was offset.");

  a_bank_page_sel: assert property (
    accept && instr_word[8]
    |=> s_r.addr == {$past(s_r.bank_select_register), s_r.instr[7:0]})
    else $error("Banked operand not on selected page.");

  a_ext_off_abs: assert property (
    accept && !ext_en && !instr_word[8]
    |=> !s_r.indexed && (s_r.addr[11:8] == 4'h0 || s_r.addr[11:8] == 4'hf))
    else $error("Indexing used while extension disabled.");

  a_add_to_acc: assert property (
    s_r.state == iloe_pkg::ST_EXEC && op_cur == iloe_pkg::OP_ADD && !s_r.instr[9]
    |=> !s_r.wr_en && s_r.acc == 8'($past(s_r.acc) + $past(mem_rd_data)))
    else $error("Add to accumulator wrong.");

  a_add_to_mem: assert property (
    s_r.state == iloe_pkg::ST_EXEC && op_cur == iloe_pkg::OP_ADD && s_r.instr[9] && !reg_wr
    |=> s_r.wr_en && s_r.wr_data == 8'($past(s_r.acc) + $past(mem_rd_data))
        && $stable(s_r.acc))
    else $error("Add to memory wrong.");

  a_add_flags_zc: assert property (
    s_r.state == iloe_pkg::ST_EXEC && op_cur == iloe_pkg::OP_ADD
    |=> s_r.flags[iloe_pkg::FLAG_C] == ({1'b0, $past(s_r.acc)} + {1'b0, $past(mem_rd_data)} > 9'h0ff)
        && s_r.flags[iloe_pkg::FLAG_Z] == (8'($past(s_r.acc) + $past(mem_rd_data)) == 8'h00))
    else $error("Add flags wrong.");

  a_bit_set_only: assert property (
    s_r.state == iloe_pkg::ST_EXEC && op_cur == iloe_pkg::OP_BSF && !reg_wr
    |=> s_r.wr_en && $stable(s_r.flags)
        && s_r.wr_data == ($past(mem_rd_data) | bit_mask(s_r.instr[11:9])))
    else $error("Bit set wrong or flags moved.");

  a_set_file_all_ones_one_cyc: assert property (
    accept && op_in == iloe_pkg::OP_SET_FILE_ALL_ONES && !reg_wr
    |=> s_r.wr_en && s_r.wr_data == 8'hff && s_r.ready && $stable(s_r.flags))
    else $error("Set all ones not single cycle.");

  a_read_then_exec: assert property (
    s_r.rd_en |=> s_r.state == iloe_pkg::ST_EXEC ##1 s_r.ready)
    else $error("Read not followed by execute.");

  a_busy_no_take: assert property (
    s_r.state != iloe_pkg::ST_IDLE |-> !s_r.ready && !accept)
    else $error("Instruction taken while busy.");

  // N and DC are rebuilt from the operands; OV compares the registered N flag with the operand signs.
  a_add_flags_nvd: assert property (
    s_r.state == iloe_pkg::ST_EXEC && op_cur == iloe_pkg::OP_ADD
    |=> s_r.flags[iloe_pkg::FLAG_N]
          == ((8'($past(s_r.acc) + $past(mem_rd_data)) & 8'h80) != 8'h00)
        && s_r.flags[iloe_pkg::FLAG_DC]
          == (5'({1'b0, $past(s_r.acc[3:0])} + {1'b0, $past(mem_rd_data[3:0])}) > 5'h0f)
        && s_r.flags[iloe_pkg::FLAG_OV]
          == ($past(s_r.acc[7]) == $past(mem_rd_data[7])
              && s_r.flags[iloe_pkg::FLAG_N] != $past(s_r.acc[7])))
    else $error("Add flags N, OV or DC wrong.");

  c_add_mem_idx: cover property (
    accept && op_in == iloe_pkg::OP_ADD && instr_word[9] && ext_en && !instr_word[8] ##3 s_r.wr_en);
  c_bsf_idx: cover property (
    accept && op_in == iloe_pkg::OP_BSF && ag_indexed ##3 s_r.wr_en);
  c_set_file_all_ones_idx: cover property (accept && op_in == iloe_pkg::OP_SET_FILE_ALL_ONES && ag_indexed);
  c_bank_abs: cover property (accept && op_in != iloe_pkg::OP_NONE && instr_word[8]);
  c_add_acc: cover property (accept && op_in == iloe_pkg::OP_ADD && !instr_word[9] ##3 !s_r.wr_en);

endmodule // iloe_exec

// file: bench/iloe_exec_bench.sv
// Self-checking bench for the indexed literal offset executor.
`timescale 1ns/10ps
module iloe_exec_bench;
  typedef struct packed {
    logic              ext;
    iloe_pkg::iloe_op_t op;
    logic              d;
    logic              a;
    logic [2:0]        b;
    logic [7:0]        k;
    logic [11:0]       frame;
    logic [3:0]        bank;
    logic [7:0]        acc;
    logic [11:0]       addr;
    logic              idx;
  } iloe_row_t;

  logic        core_clk, arst_n, ext_en, instr_valid, reg_wr, reg_rd;
  logic        instr_ready, mem_rd_en, mem_wr_en, indexed_access;
  logic [15:0] instr_word, reg_wr_data, reg_rd_data, rd_v;
  logic [11:0] mem_addr;
  logic [7:0]  mem_rd_data, mem_wr_data, acc_value;
  logic [4:0]  status_flags;
  logic [1:0]  reg_addr;
  int          bad_count, check_count;
  iloe_row_t   rows[10];
  iloe_row_t   r;

  iloe_exec u_iloe_exec (
    .core_clk                (core_clk),
    .arst_n                  (arst_n),
    .extended_set_enable_bit (ext_en),
    .instr_valid             (instr_valid),
    .instr_word              (instr_word),
    .instr_ready             (instr_ready),
    .mem_addr                (mem_addr),
    .mem_rd_en               (mem_rd_en),
    .mem_rd_data             (mem_rd_data),
    .mem_wr_en               (mem_wr_en),
    .mem_wr_data             (mem_wr_data),
    .indexed_access          (indexed_access),
    .acc_value               (acc_value),
    .status_flags            (status_flags),
    .reg_addr                (reg_addr),
    .reg_wr_data             (reg_wr_data),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rd_data             (reg_rd_data)
  );

  // ---------------------------------------------------------------
  // Clock, memory model and helpers
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [7:0] mem_val(input logic [11:0] a);
    return a[7:0] ^ 8'h3c ^ {4'h0, a[11:8]};
  endfunction

  // Outside its one valid cycle the data inverts each cycle, so a byte taken one cycle late does not pass as good.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rd_data <= 8'h00;
    end else begin
      mem_rd_data <= mem_rd_en ? mem_val(mem_addr) : ~mem_rd_data;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wr_data <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rd_data;
  endtask

  task automatic run_row(input iloe_row_t x);
    logic [15:0] w;
    logic [7:0]  m, wd;
    logic [8:0]  s;
    logic [4:0]  f;
    logic [11:0] ra, wa;
    int          nrd, nwr, nlo;
    reg_write(iloe_pkg::REG_FRAME, {4'h0, x.frame});
    ext_en <= x.ext;
    reg_write(iloe_pkg::REG_BANK, {12'h0, x.bank});
    reg_write(iloe_pkg::REG_ACC, {8'h0, x.acc});
    reg_write(iloe_pkg::REG_FLAGS, 16'h0015);
    case (x.op)
      iloe_pkg::OP_ADD: w = {iloe_pkg::OPC_ADD, x.d, x.a, x.k};
      iloe_pkg::OP_BSF: w = {iloe_pkg::OPC_BSF, x.b, x.a, x.k};
      default: w = {iloe_pkg::OPC_SET_FILE_ALL_ONES, x.a, x.k};
    endcase
    @(posedge core_clk);
    instr_valid <= 1'h1;
    instr_word <= w;
    @(posedge core_clk);
    instr_valid <= 1'h0;
    nrd = 0;
    nwr = 0;
    nlo = 0;
    ra = 12'h000;
    wa = 12'h000;
    wd = 8'h00;
    repeat (6) begin
      #1;
      if (mem_rd_en === 1'h1) begin
        nrd++;
        ra = mem_addr;
      end
      if (mem_wr_en === 1'h1) begin
        nwr++;
        wa = mem_addr;
        wd = mem_wr_data;
      end
      if (instr_ready === 1'h0) begin
        nlo++;
      end
      @(posedge core_clk);
    end
    m = mem_val(x.addr);
    s = {1'h0, x.acc} + {1'h0, m};
    f = 5'h15;
    if (x.op == iloe_pkg::OP_ADD) begin
      f[iloe_pkg::FLAG_N] = s[7];
      f[iloe_pkg::FLAG_Z] = (s[7:0] == 8'h00);
      f[iloe_pkg::FLAG_C] = s[8];
      f[iloe_pkg::FLAG_DC] = ({1'h0, x.acc[3:0]} + {1'h0, m[3:0]}) > 5'h0f;
      f[iloe_pkg::FLAG_OV] = (x.acc[7] == m[7]) && (s[7] != x.acc[7]);
    end
    #1;
    chk(indexed_access, x.idx);
    chk((x.op == iloe_pkg::OP_SET_FILE_ALL_ONES) ? wa : ra, x.addr);
    chk(nrd, (x.op == iloe_pkg::OP_SET_FILE_ALL_ONES) ? 0 : 1);
    chk(nwr, (x.op == iloe_pkg::OP_ADD && !x.d) ? 0 : 1);
    chk(nlo, (x.op == iloe_pkg::OP_SET_FILE_ALL_ONES) ? 0 : 2);
    if (nwr > 0)
      chk(wd, (x.op == iloe_pkg::OP_ADD) ? s[7:0] : (x.op == iloe_pkg::OP_BSF) ?
          (m | (8'h01 << x.b)) : iloe_pkg::ALL_ONES);
    chk(acc_value, (x.op == iloe_pkg::OP_ADD && !x.d) ? s[7:0] : x.acc);
    chk(status_flags, f);
    chk(instr_ready, 1'h1);
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end

  initial begin
    {arst_n, ext_en, instr_valid, reg_wr, reg_rd} = 5'h00;
    {instr_word, reg_wr_data, reg_addr} = 34'h0;
    bad_count = 0;
    check_count = 0;
    rows[0] = '{1'h1, iloe_pkg::OP_ADD, 1'h0, 1'h0, 3'h0, 8'h2c, 12'ha00, 4'h0, 8'h17, 12'ha2c, 1'h1};
    rows[1] = '{1'h1, iloe_pkg::OP_ADD, 1'h1, 1'h0, 3'h0, 8'h5f, 12'hffa, 4'h0, 8'h7f, 12'h059, 1'h1};
    rows[2] = '{1'h1, iloe_pkg::OP_ADD, 1'h0, 1'h0, 3'h0, 8'h60, 12'ha00, 4'h0, 8'h80, 12'h060, 1'h0};
    rows[3] = '{1'h1, iloe_pkg::OP_ADD, 1'h1, 1'h1, 3'h0, 8'h2c, 12'ha00, 4'h5, 8'hff, 12'h52c, 1'h0};
    rows[4] = '{1'h0, iloe_pkg::OP_ADD, 1'h0, 1'h0, 3'h0, 8'h2c, 12'ha00, 4'h5, 8'h00, 12'h02c, 1'h0};
    rows[5] = '{1'h0, iloe_pkg::OP_BSF, 1'h0, 1'h0, 3'h3, 8'h90, 12'ha00, 4'h5, 8'h11, 12'hf90, 1'h0};
    rows[6] = '{1'h1, iloe_pkg::OP_BSF, 1'h0, 1'h0, 3'h7, 8'h0a, 12'ha00, 4'h0, 8'h11, 12'ha0a, 1'h1};
    rows[7] = '{1'h1, iloe_pkg::OP_SET_FILE_ALL_ONES, 1'h0, 1'h0, 3'h0, 8'h2c, 12'ha00, 4'h0, 8'h22, 12'ha2c, 1'h1};
    rows[8] = '{1'h1, iloe_pkg::OP_SET_FILE_ALL_ONES, 1'h0, 1'h1, 3'h0, 8'h10, 12'ha00, 4'h3, 8'h22, 12'h310, 1'h0};
    rows[9] = '{1'h0, iloe_pkg::OP_SET_FILE_ALL_ONES, 1'h0, 1'h0, 3'h0, 8'h00, 12'ha00, 4'h3, 8'h22, 12'h000, 1'h0};
    repeat (4) @(posedge core_clk);
    arst_n <= 1'h1;
    #1;
    chk(instr_ready, 1'h1);
    chk({acc_value, status_flags}, {iloe_pkg::RST_ACC, iloe_pkg::RST_FLAGS});
    reg_read(iloe_pkg::REG_FRAME, rd_v);
    chk(rd_v, {4'h0, iloe_pkg::RST_FRAME});
    reg_read(iloe_pkg::REG_BANK, rd_v);
    chk(rd_v, {12'h0, iloe_pkg::RST_BANK});
    reg_write(iloe_pkg::REG_FRAME, 16'hffff);
    reg_read(iloe_pkg::REG_FRAME, rd_v);
    chk(rd_v, 16'h0fff);
    $display("reset and register test done");
    for (int i = 0; i < 10; i++) begin
      run_row(rows[i]);
    end
    $display("table test done");
    // Every bit number, at the top offset of the indexed range.
    for (int i = 0; i < 8; i++) begin
      r = rows[6];
      r.b = i[2:0];
      r.k = iloe_pkg::OFFSET_LIMIT;
      r.addr = 12'ha5f;
      run_row(r);
    end
    $display("bit number test done");
    // Set-all-ones is single cycle, so two may follow with no gap.
    reg_write(iloe_pkg::REG_FRAME, 16'h0100);
    @(posedge core_clk);
    instr_valid <= 1'h1;
    instr_word <= {iloe_pkg::OPC_SET_FILE_ALL_ONES, 1'h0, 8'h01};
    @(posedge core_clk);
    instr_word <= {iloe_pkg::OPC_SET_FILE_ALL_ONES, 1'h0, 8'h02};
    #1 chk({mem_wr_en, mem_addr}, {1'h1, 12'h101});
    @(posedge core_clk);
    instr_valid <= 1'h0;
    #1 chk({mem_wr_en, mem_addr}, {1'h1, 12'h102});
    $display("back to back test done");
    // A word outside the three forms is taken and touches nothing.
    @(posedge core_clk);
    instr_valid <= 1'h1;
    instr_word <= 16'hffff;
    @(posedge core_clk);
    instr_valid <= 1'h0;
    #1 chk({mem_rd_en, mem_wr_en, instr_ready}, 3'h1);
    $display("no-operation test done");
    reg_write(iloe_pkg::REG_ACC, 16'h0055);
    @(posedge core_clk);
    arst_n <= 1'h0;
    #1 chk({acc_value, instr_ready}, {iloe_pkg::RST_ACC, 1'h1});
    @(posedge core_clk);
    arst_n <= 1'h1;
    // The synchroniser restarts empty, so the first word after release is not indexed.
    instr_valid <= 1'h1;
    instr_word <= {iloe_pkg::OPC_SET_FILE_ALL_ONES, 1'h0, 8'h01};
    @(posedge core_clk);
    instr_valid <= 1'h0;
    #1 chk({mem_wr_en, indexed_access, mem_addr}, {2'h2, 12'h001});
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule // iloe_exec_bench
